// [core/wot_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "wot_regs.svh"
module wot_top #(
  parameter int BASE_SHIFT = `WOT_BASE_SHIFT,
  parameter int HOLD_CYC = `WOT_RST_HOLD
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`WOT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic debug_mode_pin,
  output logic overflow_nmi_req,
  output logic nmi_source_flag0,
  output logic fault_out_n,
  output logic wdt_reset_req,
  output logic clock_reinit_req,
  output logic irq
);
  localparam int CNT_W = BASE_SHIFT + `WOT_PER_SPAN;

  logic run_allow_reg;
  wot_pkg::wot_period_t period_reg;
  logic idle_keep_running_reg;
  logic overflow_action_sel_reg;
  wot_pkg::wot_state_t state_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] count_max;
  logic fault_low_reg;
  logic nmi_req_reg;
  logic flag0_reg;
  logic reinit_reg;
  logic [`WOT_EV_W-1:0] stat_reg;
  logic [`WOT_EV_W-1:0] ien_reg;
  logic [`WOT_EV_W-1:0] ev_set;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [31:0] rdata;
  logic addr_ok;
  logic wr_acc;
  logic mode_wr;
  logic cmd_wr;
  logic iclr_wr;
  logic ien_wr;
  logic code_clear;
  logic code_disable;
  logic code_bad;
  logic debug_mode;
  logic hold_active;
  logic count_en;
  logic overflow;
  logic ovf_nmi;
  logic ovf_rst;
  logic boot_done_reg;
  wot_pkg::wot_code_t command_code;

  // Debug request arrives from the debug port, outside this clock
  wot_sync3 u_dbg_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(debug_mode_pin),
    .level_out(debug_mode)
  );

  // APB decode; zero wait states so pready is simply high
  always_comb begin
    case (paddr)
      `WOT_OFF_MODE, `WOT_OFF_CMD, `WOT_OFF_STAT, `WOT_OFF_ICLR,
      `WOT_OFF_IEN, `WOT_OFF_CNT, `WOT_OFF_STATE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite && addr_ok && pstrb[0];
  assign mode_wr = wr_acc && (paddr == `WOT_OFF_MODE);
  assign cmd_wr = wr_acc && (paddr == `WOT_OFF_CMD);
  assign iclr_wr = wr_acc && (paddr == `WOT_OFF_ICLR);
  assign ien_wr = wr_acc && (paddr == `WOT_OFF_IEN);
  assign command_code = pwdata[7:0];

  assign code_clear = cmd_wr && (command_code == `WOT_CODE_CLEAR);
  assign code_disable = cmd_wr && (command_code == `WOT_CODE_DISABLE);
  assign code_bad = cmd_wr && !code_clear && !code_disable;

  // unused and write-only fields read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      `WOT_OFF_MODE: begin
        rdata[`WOT_BIT_RUN] = run_allow_reg;
        rdata[`WOT_BIT_PER_HI:`WOT_BIT_PER_LO] = period_reg;
        rdata[`WOT_BIT_IDLE] = idle_keep_running_reg;
        rdata[`WOT_BIT_ACT] = overflow_action_sel_reg;
      end
      `WOT_OFF_STAT: rdata[`WOT_EV_W-1:0] = stat_reg;
      `WOT_OFF_IEN: rdata[`WOT_EV_W-1:0] = ien_reg;
      `WOT_OFF_CNT: rdata[CNT_W-1:0] = count_reg;
      `WOT_OFF_STATE: begin
        rdata[0] = (state_reg == wot_pkg::WOT_STOPPED);
        rdata[1] = fault_low_reg;
        rdata[2] = hold_active;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rdata;
      pslverr_reg <= !addr_ok;
    end
  end
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  // mode register and its reset values
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_allow_reg <= `WOT_RST_RUN;
      period_reg <= `WOT_RST_PER;
      idle_keep_running_reg <= `WOT_RST_IDLE;
      overflow_action_sel_reg <= `WOT_RST_ACT;
    end else if (mode_wr) begin
      run_allow_reg <= pwdata[`WOT_BIT_RUN];
      idle_keep_running_reg <= pwdata[`WOT_BIT_IDLE];
      overflow_action_sel_reg <= pwdata[`WOT_BIT_ACT];
      // prohibited codes keep the old period
      if (pwdata[`WOT_BIT_PER_HI:`WOT_BIT_PER_LO] <= `WOT_PER_MAX) begin
        period_reg <= pwdata[`WOT_BIT_PER_HI:`WOT_BIT_PER_LO];
      end
    end
  end

  // Run state; a write of run bit 0 alone must not stop the timer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= wot_pkg::WOT_RUN;
    end else begin
      case (state_reg)
        wot_pkg::WOT_RUN: begin
          // disable only after run bit already cleared
          if (code_disable && !run_allow_reg) begin
            state_reg <= wot_pkg::WOT_STOPPED;
          end
        end
        wot_pkg::WOT_STOPPED: begin
          if (mode_wr && pwdata[`WOT_BIT_RUN]) begin
            state_reg <= wot_pkg::WOT_RUN;
          end
        end
        default: state_reg <= wot_pkg::WOT_RUN;
      endcase
    end
  end

  // terminal count from the period code
  assign count_max = (CNT_W'(1) << (BASE_SHIFT + `WOT_SHIFT_STEP * int'(period_reg))) - CNT_W'(1);

  // idle and debug freeze; also frozen while reset is held
  assign count_en = (state_reg == wot_pkg::WOT_RUN) && !debug_mode
    && !(idle_mode && !idle_keep_running_reg) && !hold_active;

  // overflow at the last count of the period
  assign overflow = count_en && (count_reg == count_max);
  assign ovf_nmi = overflow && !overflow_action_sel_reg;
  assign ovf_rst = overflow && overflow_action_sel_reg;

  always_comb begin
    count_next = count_reg;
    if (code_clear || (code_disable && !run_allow_reg)) begin
      count_next = '0;
    end else if (overflow) begin
      count_next = '0;
    end else if (count_en) begin
      count_next = count_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // NMI request and source flag pulse together
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_req_reg <= 1'b0;
      flag0_reg <= 1'b0;
    end else begin
      nmi_req_reg <= ovf_nmi;
      flag0_reg <= ovf_nmi;
    end
  end
  assign overflow_nmi_req = nmi_req_reg;
  assign nmi_source_flag0 = flag0_reg;

  // fault level; a new overflow beats a same-cycle clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_low_reg <= 1'b0;
    end else if (ovf_nmi) begin
      fault_low_reg <= 1'b1;
    end else if (code_clear) begin
      fault_low_reg <= 1'b0;
    end
  end
  assign fault_out_n = !fault_low_reg;

  // reset held for the documented number of states
  wot_hold #(
    .HOLD(HOLD_CYC)
  ) u_rst_hold (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(ovf_rst),
    .active(hold_active)
  );

  // clock gear returned to undivided oscillator
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reinit_reg <= 1'b0;
    end else begin
      reinit_reg <= ovf_rst;
    end
  end

  assign wdt_reset_req = hold_active;
  assign clock_reinit_req = reinit_reg;

  // Sticky events; set wins over a same-cycle clear
  assign ev_set = {code_bad, ovf_rst, ovf_nmi};

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~(iclr_wr ? pwdata[`WOT_EV_W-1:0] : '0)) | ev_set;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ien_reg <= '0;
    end else if (ien_wr) begin
      ien_reg <= pwdata[`WOT_EV_W-1:0];
    end
  end

  assign irq = |(stat_reg & ien_reg);

  // Marks the first cycle after reset release
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_done_reg <= 1'b0;
    end else begin
      boot_done_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_disable_steps;
    mode_wr && !pwdata[`WOT_BIT_RUN] ##[1:20] (code_disable && !run_allow_reg);
  endsequence

  sequence s_nmi_overflow;
    ovf_nmi ##1 (overflow_nmi_req && nmi_source_flag0);
  endsequence

  sequence s_reset_held;
    ovf_rst ##1 (wdt_reset_req && clock_reinit_req) ##1 wdt_reset_req[*8];
  endsequence

  AST_BOOT_VALUES: assert property (
    !boot_done_reg |-> (run_allow_reg && period_reg == 3'h0 && overflow_action_sel_reg
      && state_reg == wot_pkg::WOT_RUN))
    else $error("mode register reset values wrong");

  AST_BOOT_COUNTS: assert property (
    (!boot_done_reg && !debug_mode && !idle_mode) |=> (count_reg == CNT_W'(1)))
    else $error("counter did not start after reset");

  AST_PERIOD_LEGAL: assert property (
    period_reg <= 3'h5)
    else $error("prohibited period code stored");

  AST_OVF_AT_MAX: assert property (
    (count_en && count_reg == count_max && !cmd_wr) |=> (count_reg == '0 && $past(overflow)))
    else $error("overflow not at terminal count");

  AST_CLEAR_CODE: assert property (
    code_clear |=> (count_reg == '0))
    else $error("clear code did not zero counter");

  AST_DISABLE_ORDER: assert property (
    s_disable_steps |=> (state_reg == wot_pkg::WOT_STOPPED && count_reg == '0))
    else $error("disable sequence did not stop timer");

  AST_DISABLE_NEEDS_CLEAR: assert property (
    (code_disable && run_allow_reg && state_reg == wot_pkg::WOT_RUN) |=> (state_reg == wot_pkg::WOT_RUN))
    else $error("disable accepted with run bit set");

  AST_RESTART: assert property (
    (mode_wr && pwdata[`WOT_BIT_RUN]) |=> (state_reg == wot_pkg::WOT_RUN && run_allow_reg))
    else $error("run bit did not restart timer");

  AST_IDLE_STOP: assert property (
    (idle_mode && !idle_keep_running_reg && !cmd_wr) |=> $stable(count_reg))
    else $error("counter moved while idle");

  AST_DEBUG_FREEZE: assert property (
    (debug_mode && !cmd_wr) |=> $stable(count_reg))
    else $error("counter moved in debug mode");

  AST_NMI_FLAG: assert property (
    s_nmi_overflow |-> ##1 !overflow_nmi_req || $past(ovf_nmi))
    else $error("nmi request not single pulse");

  AST_NMI_RAISED: assert property (
    ovf_nmi |=> (overflow_nmi_req && nmi_source_flag0 && !wdt_reset_req))
    else $error("nmi overflow missing request or flag");

  AST_FAULT_PIN: assert property (
    ovf_nmi |=> (!fault_out_n until_with code_clear))
    else $error("fault pin not held low until clear");

  AST_FAULT_RELEASE: assert property (
    (code_clear && !ovf_nmi) |=> fault_out_n)
    else $error("fault pin not released by clear");

  AST_RESET_HOLD: assert property (
    s_reset_held |-> ##23 (wdt_reset_req ##1 !wdt_reset_req))
    else $error("reset hold length wrong");

  AST_BAD_CODE: assert property (
    (code_bad && !overflow) |=> (state_reg == $past(state_reg) && count_reg != '0 || $past(count_reg) == '0
      || !$past(count_en)))
    else $error("unknown code changed the timer");

  AST_IRQ_LEVEL: assert property (
    (|(ev_set & ien_reg) && !ien_wr) |=> (irq && ((stat_reg & $past(ev_set)) == $past(ev_set))))
    else $error("interrupt level inconsistent");
endmodule
`default_nettype wire

// [core/wot_regs.svh]
`ifndef WOT_REGS_SVH
`define WOT_REGS_SVH

`define WOT_ADDR_W 12
`define WOT_OFF_MODE 12'h000
`define WOT_OFF_CMD 12'h004
`define WOT_OFF_STAT 12'h008
`define WOT_OFF_ICLR 12'h00C
`define WOT_OFF_IEN 12'h010
`define WOT_OFF_CNT 12'h014
`define WOT_OFF_STATE 12'h018

`define WOT_BIT_RUN 7
`define WOT_BIT_PER_HI 6
`define WOT_BIT_PER_LO 4
`define WOT_BIT_IDLE 2
`define WOT_BIT_ACT 1

`define WOT_RST_RUN 1'b1
`define WOT_RST_PER 3'h0
`define WOT_RST_IDLE 1'b0
`define WOT_RST_ACT 1'b1

`define WOT_PER_MAX 3'h5
`define WOT_CODE_CLEAR 8'h4E
`define WOT_CODE_DISABLE 8'hB1

`define WOT_BASE_SHIFT 15
`define WOT_SHIFT_STEP 2
`define WOT_PER_SPAN 10
`define WOT_RST_HOLD 32

`define WOT_EV_W 3
`define WOT_EV_NMI 0
`define WOT_EV_RST 1
`define WOT_EV_BAD 2

`endif

// [core/wot_pkg.sv]
package wot_pkg;
  typedef enum logic [0:0] {
    WOT_RUN,
    WOT_STOPPED
  } wot_state_t;

  typedef logic [7:0] wot_code_t;
  typedef logic [2:0] wot_period_t;
endpackage

// [core/wot_sync3.sv]
`timescale 1ns/100ps
`default_nettype none
// Three-stage pin synchroniser; output moves once stages two and three agree
module wot_sync3 (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level_out
);
  logic meta_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end
endmodule
`default_nettype wire

// [core/wot_hold.sv]
`timescale 1ns/100ps
`default_nettype none
// Stretches a start pulse into a level lasting HOLD clocks
module wot_hold #(
  parameter int HOLD = 32
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic start,
  output logic active
);
  localparam int CW = $clog2(HOLD + 1);
  logic [CW-1:0] left_reg;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      left_reg <= '0;
    end else if (start) begin
      left_reg <= CW'(HOLD);
    end else if (left_reg != '0) begin
      left_reg <= left_reg - CW'(1);
    end
  end

  assign active = (left_reg != '0);
endmodule
`default_nettype wire

// [tb/wot_top_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "wot_regs.svh"
module wot_top_test;
  localparam int BS = 2;
  localparam int HOLD = 32;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic idle_mode = 1'b0;
  logic debug_mode_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, overflow_nmi_req, nmi_source_flag0, fault_out_n, wdt_reset_req, clock_reinit_req, irq;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int nmi_cnt = 0;
  int last_nmi = 0;
  int nmi_gap = 0;
  int hold_run = 0;
  int last_hold = 0;
  int k, n0;
  logic reinit_ok = 1'b0;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] codes [8] = '{8'h00, 8'h4F, 8'hB0, 8'hFF, 8'h4D, 8'hB2, 8'h55, 8'hAA};

  wot_top #(.BASE_SHIFT(BS), .HOLD_CYC(HOLD)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .debug_mode_pin(debug_mode_pin),
    .overflow_nmi_req(overflow_nmi_req), .nmi_source_flag0(nmi_source_flag0), .fault_out_n(fault_out_n),
    .wdt_reset_req(wdt_reset_req), .clock_reinit_req(clock_reinit_req), .irq(irq));

  always #5 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    bad_count++;
    $display("ERROR %s expected completion seen timeout", what);
    tally_and_finish();
  endtask

  // Outputs sampled mid-cycle, away from the launching edge
  always @(negedge ref_clk) begin
    cyc++;
    if (overflow_nmi_req === 1'b1) begin
      nmi_gap = cyc - last_nmi;
      last_nmi = cyc;
      nmi_cnt++;
      check("nmi_flag0", {31'h0, nmi_source_flag0}, 32'h0000_0001);
      check("fault_low", {31'h0, fault_out_n}, 32'h0000_0000);
    end
    if (wdt_reset_req === 1'b1) begin
      if (hold_run == 0) reinit_ok = clock_reinit_req;
      hold_run++;
    end else if (hold_run != 0) begin
      last_hold = hold_run;
      hold_run = 0;
    end
  end

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [3:0] strb,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    pstrb <= strb;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    // Answer taken at the very edge that sees pready high
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) timeout("apb");
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, addr, d, 4'hF, r, e);
  endtask

  task automatic rdc(input string what, input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, addr, 32'h0000_0000, 4'hF, r, e);
    check(what, r, exp);
  endtask

  task automatic wait_nmi(input int n, input int bound);
    int c;
    c = 0;
    while (nmi_cnt < n) begin
      @(negedge ref_clk);
      c++;
      if (c > bound) timeout("nmi_wait");
    end
  endtask

  task automatic quiet(input string what, input int cycles);
    int q;
    q = nmi_cnt;
    repeat (cycles) @(negedge ref_clk);
    check(what, 32'(nmi_cnt), 32'(q));
  endtask

  function automatic logic [31:0] mode(input logic run, input logic [2:0] per, input logic idle, input logic act);
    return {24'h00_0000, run, per, 1'b0, idle, act, 1'b0};
  endfunction

  task automatic stop_timer();
    wr(`WOT_OFF_MODE, mode(1'b0, 3'h1, 1'b0, 1'b0));
    wr(`WOT_OFF_CMD, 32'h0000_00B1);
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    timeout("run");
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc("mode_rst", `WOT_OFF_MODE, 32'h0000_0082);
    k = 0;
    while (last_hold == 0) begin
      @(negedge ref_clk);
      k++;
      if (k > 200) timeout("hold_wait");
    end
    check("hold_len", 32'(last_hold), 32'(HOLD));
    check("reinit", {31'h0, reinit_ok}, 32'h0000_0001);
    $display("test reset_overflow done");
    wr(`WOT_OFF_IEN, 32'h0000_0001);
    for (int p = 0; p < 6; p++) begin
      wr(`WOT_OFF_MODE, mode(1'b1, 3'(p), 1'b0, 1'b0));
      n0 = nmi_cnt;
      wait_nmi(n0 + 2, 3 * (1 << (BS + 2 * p)) + 80);
      check("period", 32'(nmi_gap), 32'(1 << (BS + 2 * p)));
    end
    @(negedge ref_clk);
    check("irq_on", {31'h0, irq}, 32'h0000_0001);
    wr(`WOT_OFF_IEN, 32'h0000_0000);
    @(negedge ref_clk);
    check("irq_masked", {31'h0, irq}, 32'h0000_0000);
    $display("test periods done");
    wr(`WOT_OFF_MODE, 32'h0000_00E0);
    rdc("per_110", `WOT_OFF_MODE, 32'h0000_00D0);
    wr(`WOT_OFF_MODE, 32'h0000_00F4);
    rdc("per_111", `WOT_OFF_MODE, 32'h0000_00D4);
    apb(1'b1, `WOT_OFF_MODE, 32'h0000_0000, 4'hE, rdat, rerr);
    rdc("strb_off", `WOT_OFF_MODE, 32'h0000_00D4);
    wr(`WOT_OFF_MODE, 32'hFFFF_FF99);
    rdc("unused", `WOT_OFF_MODE, 32'h0000_0090);
    rdc("cmd_rd", `WOT_OFF_CMD, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000, 4'hF, rdat, rerr);
    check("unmapped_err", {31'h0, rerr}, 32'h0000_0001);
    check("unmapped_data", rdat, 32'h0000_0000);
    $display("test mode_fields done");
    // Counter may sit above the new shorter period; restart it
    wr(`WOT_OFF_CMD, 32'h0000_004E);
    wait_nmi(nmi_cnt + 1, 100);
    wr(`WOT_OFF_CMD, 32'h0000_0055);
    @(negedge ref_clk);
    check("fault_bad", {31'h0, fault_out_n}, 32'h0000_0000);
    wr(`WOT_OFF_CMD, 32'h0000_004E);
    @(negedge ref_clk);
    check("fault_clr", {31'h0, fault_out_n}, 32'h0000_0001);
    n0 = nmi_cnt;
    // Kicks every 3 cycles against a 16-cycle period
    repeat (8) wr(`WOT_OFF_CMD, 32'h0000_004E);
    check("kick", 32'(nmi_cnt), 32'(n0));
    n0 = nmi_cnt;
    foreach (codes[i]) wr(`WOT_OFF_CMD, {24'h00_0000, codes[i]});
    check("bad_code", 32'(nmi_cnt > n0), 32'h0000_0001);
    rdc("status", `WOT_OFF_STAT, 32'h0000_0007);
    $display("test clear_codes done");
    wr(`WOT_OFF_MODE, mode(1'b1, 3'h1, 1'b0, 1'b0));
    wr(`WOT_OFF_CMD, 32'h0000_00B1);
    wait_nmi(nmi_cnt + 1, 40);
    wr(`WOT_OFF_MODE, mode(1'b0, 3'h1, 1'b0, 1'b0));
    wait_nmi(nmi_cnt + 1, 40);
    wr(`WOT_OFF_CMD, 32'h0000_00B1);
    rdc("cnt_off", `WOT_OFF_CNT, 32'h0000_0000);
    rdc("state_off", `WOT_OFF_STATE, 32'h0000_0003);
    quiet("off_quiet", 60);
    wr(`WOT_OFF_ICLR, 32'h0000_0007);
    rdc("stat_clr", `WOT_OFF_STAT, 32'h0000_0000);
    wr(`WOT_OFF_IEN, 32'h0000_0001);
    rdc("ien", `WOT_OFF_IEN, 32'h0000_0001);
    check("irq_clr", {31'h0, irq}, 32'h0000_0000);
    $display("test disable done");
    @(posedge ref_clk);
    debug_mode_pin <= 1'b1;
    idle_mode <= 1'b1;
    // Debug pin passes a synchroniser first
    repeat (6) @(posedge ref_clk);
    wr(`WOT_OFF_MODE, mode(1'b1, 3'h1, 1'b1, 1'b0));
    quiet("dbg_quiet", 60);
    rdc("cnt_dbg", `WOT_OFF_CNT, 32'h0000_0000);
    @(posedge ref_clk);
    debug_mode_pin <= 1'b0;
    wait_nmi(nmi_cnt + 1, 40);
    @(negedge ref_clk);
    check("irq_nmi", {31'h0, irq}, 32'h0000_0001);
    stop_timer();
    wr(`WOT_OFF_MODE, mode(1'b1, 3'h1, 1'b0, 1'b0));
    quiet("idle_quiet", 60);
    rdc("cnt_idle", `WOT_OFF_CNT, 32'h0000_0000);
    @(posedge ref_clk);
    idle_mode <= 1'b0;
    wait_nmi(nmi_cnt + 1, 40);
    $display("test debug_idle done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
